// >>> common/mac_pkg.sv
// Constants, types and state record of the multiply-accumulate unit
package mac_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [11:0] MAC_OFS_OPA = 12'h000;
  localparam logic [11:0] MAC_OFS_OPB = 12'h004;
  localparam logic [11:0] MAC_OFS_ACC_UP = 12'h008;
  localparam logic [11:0] MAC_OFS_ACC_MID = 12'h00C;
  localparam logic [11:0] MAC_OFS_ACC_LO = 12'h010;
  localparam logic [11:0] MAC_OFS_PROD_HI = 12'h014;
  localparam logic [11:0] MAC_OFS_PROD_LO = 12'h018;
  localparam logic [11:0] MAC_OFS_CTL = 12'h01C;
  localparam logic [11:0] MAC_OFS_IRQ_STS = 12'h020;
  localparam logic [11:0] MAC_OFS_IRQ_MSK = 12'h024;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int unsigned MAC_CTL_SGN_BIT = 0;
  localparam int unsigned MAC_CTL_OP_LSB = 1;
  localparam int unsigned MAC_CTL_TRIG_BIT = 3;
  localparam int unsigned MAC_CTL_OVF_BIT = 8;
  localparam int unsigned MAC_CTL_BUSY_BIT = 9;
  localparam int unsigned MAC_IRQ_DONE_BIT = 0;
  localparam int unsigned MAC_IRQ_OVF_BIT = 1;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] MAC_RST_WORD = 16'h0000;
  localparam logic [47:0] MAC_RST_ACC = 48'h0000_0000_0000;
  localparam logic [33:0] MAC_RST_PROD = 34'h0_0000_0000;
  localparam logic [1:0] MAC_RST_IRQ = 2'h0;
  localparam logic [31:0] MAC_RST_RDATA = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MAC_OP_MUL = 2'b00,
    MAC_OP_ACC = 2'b01,
    MAC_OP_SUB = 2'b10,
    MAC_OP_NEG = 2'b11
  } mac_op_t;

  typedef enum logic [1:0] {
    MAC_ST_IDLE = 2'b00,
    MAC_ST_MUL = 2'b01,
    MAC_ST_ACC = 2'b10
  } mac_state_t;

  typedef struct packed {
    logic [15:0] opa;
    logic [15:0] opb;
    logic [47:0] acc;
    logic [33:0] prod;
    logic sgn;
    mac_op_t op;
    logic trig_both;
    logic ovf;
    logic a_loaded;
    logic b_loaded;
    logic run_sgn;
    mac_op_t run_op;
    mac_state_t state;
    logic [1:0] irq_sts;
    logic [1:0] irq_msk;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
  } mac_regs_t;

endpackage

// >>> hw/mac_unit.sv
// Multiply-accumulate peripheral with APB register slave
//
// Functional notes
// - 16x16 plain multiply delivers the whole product one cycle after start.
// - 48-bit accumulator updates one cycle after the multiply cycle for accumulate/subtract, in it for plain and negate.
// - Seven operations; plain and negate take one cycle, accumulate/subtract two.
// - Operands go to A and B; loading them starts the chosen operation.
// - Accumulator is readable as upper, middle and lower 16-bit words.
// - Accumulator overflow is a status bit in the control/status register.
// - Plain multiply product appears in a read-only high/low result pair.
// - Accumulate/subtract results valid after one wait cycle; software waits.
// - Multiplier array reads operand registers A and B, yields 34-bit product.
// - Adder sums product with zero, or with accumulator for accumulating ops.
// - Final sum is read straight from the accumulator registers.
// - Negate/subtract complement A and correct partial products for exact result.
//
// Added by the designer: the APB register port and the placing of the registers.
module mac_unit
  import mac_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Register index, 4'hF for unmapped
  function automatic logic [3:0] mac_dec(input logic [11:0] a);
    case (a)
      MAC_OFS_OPA: return 4'h0;
      MAC_OFS_OPB: return 4'h1;
      MAC_OFS_ACC_UP: return 4'h2;
      MAC_OFS_ACC_MID: return 4'h3;
      MAC_OFS_ACC_LO: return 4'h4;
      MAC_OFS_PROD_HI: return 4'h5;
      MAC_OFS_PROD_LO: return 4'h6;
      MAC_OFS_CTL: return 4'h7;
      MAC_OFS_IRQ_STS: return 4'h8;
      MAC_OFS_IRQ_MSK: return 4'h9;
      default: return 4'hF;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Control helpers
  // ----------------------------------------------------------------
  // Accumulate and subtract keep the unit busy for a second cycle,
  // and must be waited for before the accumulator is read
  function automatic logic mac_two_cycle(input mac_op_t op);
    return op == MAC_OP_ACC || op == MAC_OP_SUB;
  endfunction

  // Unsigned negate code is a plain unsigned multiply: only seven ops exist
  function automatic logic mac_negates(input logic sgn, input mac_op_t op);
    logic n;
    n = op == MAC_OP_SUB;
    if (sgn && op == MAC_OP_NEG) begin
      n = 1'b1;
    end
    return n;
  endfunction

  // Start on any write to B, or, in both-operand mode, once A and B
  // are both fresh; a start while busy is dropped but the operand is kept
  function automatic logic mac_start(
    input logic idle,
    input logic both,
    input logic a_ld,
    input logic b_ld,
    input logic [3:0] idx
  );
    logic s;
    s = 1'b0;
    if (idle && both) begin
      s = a_ld && b_ld && (idx == 4'h0 || idx == 4'h1);
    end else if (idle) begin
      s = idx == 4'h1;
    end
    return s;
  endfunction

  // ----------------------------------------------------------------
  // Arithmetic
  // ----------------------------------------------------------------
  // Shift-and-add array of 17 partial-product rows on 17-bit extended
  // operands; the top row weighs minus two to the sixteenth, which is the
  // sign correction that keeps signed and negated products exact
  function automatic logic signed [33:0] mac_array(
    input logic signed [16:0] ax,
    input logic signed [16:0] bx
  );
    logic signed [33:0] ae;
    logic signed [33:0] row [17];
    logic signed [33:0] tot;
    ae = 34'(ax);
    tot = 34'sh0;
    for (int i = 0; i < 17; i++) begin
      row[i] = bx[i] ? (ae <<< i) : 34'sh0;
    end
    row[16] = -row[16];
    for (int i = 0; i < 17; i++) begin
      tot = tot + row[i];
    end
    return tot;
  endfunction

  // The product meets only the lower 32 bits; the upper word just takes
  // the carry and the extension, so the wide adder stays 32 bits
  function automatic logic [48:0] mac_accum(
    input logic [47:0] acc,
    input logic [33:0] prod,
    input logic sgn
  );
    logic [32:0] lo;
    logic [16:0] hi;
    logic [16:0] hi_ext;
    logic [16:0] p_ext;
    lo = {1'b0, acc[31:0]} + {1'b0, prod[31:0]};
    hi_ext = sgn ? {acc[47], acc[47:32]} : {1'b0, acc[47:32]};
    p_ext = {{15{prod[33]}}, prod[33:32]};
    hi = hi_ext + p_ext + 17'(lo[32]);
    return {hi, lo[31:0]};
  endfunction

  // Signed results leave range when the two top sum bits disagree;
  // unsigned ones on a carry or borrow out of bit 47
  function automatic logic mac_ovf(input logic [48:0] s, input logic sgn);
    logic o;
    o = s[48];
    if (sgn) begin
      o = s[48] ^ s[47];
    end
    return o;
  endfunction

  // ----------------------------------------------------------------
  // Bus read-back and writes
  // ----------------------------------------------------------------
  // Control/status word: latched choices, sticky overflow and busy
  function automatic logic [31:0] mac_ctl_word(input mac_regs_t s);
    logic [31:0] w;
    w = MAC_RST_RDATA;
    w[MAC_CTL_SGN_BIT] = s.sgn;
    w[MAC_CTL_OP_LSB +: 2] = s.op;
    w[MAC_CTL_TRIG_BIT] = s.trig_both;
    w[MAC_CTL_OVF_BIT] = s.ovf;
    w[MAC_CTL_BUSY_BIT] = s.state != MAC_ST_IDLE;
    return w;
  endfunction

  // Read word of one register; unused upper bits read as zero
  function automatic logic [31:0] mac_rd(input logic [3:0] idx, input mac_regs_t s);
    logic [31:0] d;
    d = MAC_RST_RDATA;
    case (idx)
      4'h0: d[15:0] = s.opa;
      4'h1: d[15:0] = s.opb;
      4'h2: d[15:0] = s.acc[47:32];
      4'h3: d[15:0] = s.acc[31:16];
      4'h4: d[15:0] = s.acc[15:0];
      4'h5: d[15:0] = s.prod[31:16];
      4'h6: d[15:0] = s.prod[15:0];
      4'h7: d = mac_ctl_word(s);
      4'h8: d[1:0] = s.irq_sts;
      4'h9: d[1:0] = s.irq_msk;
      default: d = MAC_RST_RDATA;
    endcase
    return d;
  endfunction

  // Software writes; hardware updates later in the cycle override them
  function automatic mac_regs_t mac_wr(
    input logic [3:0] idx,
    input logic [31:0] d,
    input mac_regs_t s
  );
    mac_regs_t n;
    n = s;
    case (idx)
      4'h0: begin
        n.opa = d[15:0];
        n.a_loaded = 1'b1;
      end
      4'h1: begin
        n.opb = d[15:0];
        n.b_loaded = 1'b1;
      end
      4'h2: n.acc[47:32] = d[15:0];
      4'h3: n.acc[31:16] = d[15:0];
      4'h4: n.acc[15:0] = d[15:0];
      4'h7: begin
        n.sgn = d[MAC_CTL_SGN_BIT];
        n.op = mac_op_t'(d[MAC_CTL_OP_LSB +: 2]);
        n.trig_both = d[MAC_CTL_TRIG_BIT];
        if (d[MAC_CTL_OVF_BIT]) begin
          n.ovf = 1'b0;
        end
      end
      4'h8: n.irq_sts = s.irq_sts & ~d[1:0];
      4'h9: n.irq_msk = d[1:0];
      default: ;
    endcase
    return n;
  endfunction

  // Level interrupt from the next flags, so it rises on the same clock as a flag
  function automatic logic mac_irq(input logic [1:0] sts, input logic [1:0] msk);
    return |(sts & msk);
  endfunction

  // Negation complements A and adds B back, since -A equals ~A + 1
  function automatic logic signed [33:0] mac_mul(
    input logic [15:0] a,
    input logic [15:0] b,
    input logic sgn,
    input logic neg
  );
    logic signed [16:0] ax;
    logic signed [16:0] bx;
    logic signed [33:0] pr;
    ax = {sgn & a[15], a};
    bx = {sgn & b[15], b};
    if (neg) begin
      ax = ~ax;
    end
    // Array sees the register values directly; nothing is pipelined
    pr = mac_array(ax, bx);
    if (neg) begin
      pr = pr + 34'(bx);
    end
    return pr;
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  mac_regs_t r;
  mac_regs_t r_nxt;

  logic signed [33:0] mul_p;
  logic [48:0] sum;
  logic ovf_evt;
  logic done_evt;
  logic setup;
  logic wr;
  logic start;
  logic [3:0] wr_idx;
  logic [3:0] rd_idx;
  logic neg_now;

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign prdata = r.prdata;
  assign pready = r.pready;
  assign pslverr = r.pslverr;
  assign irq = r.irq;

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    r_nxt = r;
    // Bus decode
    setup = psel & ~penable;
    wr = psel & penable & pwrite & r.pready;
    wr_idx = wr ? mac_dec(paddr) : 4'hF;
    rd_idx = mac_dec(paddr);
    ovf_evt = 1'b0;
    done_evt = 1'b0;
    start = 1'b0;

    // Datapath operands and sum
    neg_now = mac_negates(r.run_sgn, r.run_op);
    mul_p = mac_mul(r.opa, r.opb, r.run_sgn, neg_now);
    sum = mac_accum(r.acc, r.prod, r.run_sgn);

    // Zero-wait APB: ready and read data prepared during setup
    r_nxt.pready = setup;
    r_nxt.pslverr = setup && rd_idx == 4'hF;
    if (setup) begin
      r_nxt.prdata = mac_rd(rd_idx, r);
    end

    // Register writes
    r_nxt = mac_wr(wr_idx, pwdata, r_nxt);

    // Operand loading is the only start; busy ignores new triggers
    start = mac_start(r.state == MAC_ST_IDLE, r.trig_both, r_nxt.a_loaded, r_nxt.b_loaded,
      wr_idx);
    if (start) begin
      r_nxt.state = MAC_ST_MUL;
      r_nxt.run_sgn = r.sgn;
      r_nxt.run_op = r.op;
      r_nxt.a_loaded = 1'b0;
      r_nxt.b_loaded = 1'b0;
    end

    // Datapath sequencing; hardware updates win over same-cycle writes
    case (r.state)
      MAC_ST_IDLE: ;
      MAC_ST_MUL: begin
        r_nxt.prod = mul_p;
        if (mac_two_cycle(r.run_op)) begin
          r_nxt.state = MAC_ST_ACC;
        end else begin
          r_nxt.acc = {{14{mul_p[33]}}, mul_p};
          r_nxt.state = MAC_ST_IDLE;
          done_evt = 1'b1;
        end
      end
      MAC_ST_ACC: begin
        r_nxt.acc = sum[47:0];
        ovf_evt = mac_ovf(sum, r.run_sgn);
        r_nxt.state = MAC_ST_IDLE;
        done_evt = 1'b1;
      end
      default: r_nxt.state = MAC_ST_IDLE;
    endcase

    // Sticky flags: a set in the clearing cycle wins
    if (ovf_evt) begin
      r_nxt.ovf = 1'b1;
      r_nxt.irq_sts[MAC_IRQ_OVF_BIT] = 1'b1;
    end
    if (done_evt) begin
      r_nxt.irq_sts[MAC_IRQ_DONE_BIT] = 1'b1;
    end
    r_nxt.irq = mac_irq(r_nxt.irq_sts, r_nxt.irq_msk);
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // Datapath, control and flags
      r.opa <= MAC_RST_WORD;
      r.opb <= MAC_RST_WORD;
      r.acc <= MAC_RST_ACC;
      r.prod <= MAC_RST_PROD;
      r.sgn <= 1'b0;
      r.op <= MAC_OP_MUL;
      r.trig_both <= 1'b0;
      r.ovf <= 1'b0;
      r.a_loaded <= 1'b0;
      r.b_loaded <= 1'b0;
      r.run_sgn <= 1'b0;
      r.run_op <= MAC_OP_MUL;
      r.state <= MAC_ST_IDLE;
      r.irq_sts <= MAC_RST_IRQ;
      r.irq_msk <= MAC_RST_IRQ;
      // Bus outputs stay low until the first setup
      r.prdata <= MAC_RST_RDATA;
      r.pready <= 1'b0;
      r.pslverr <= 1'b0;
      r.irq <= 1'b0;
    end else begin
      r <= r_nxt;
    end
  end

endmodule

// >>> tb/mac_apb_host.sv
// Processor-core model: a bus master issuing one register transfer at a time
module mac_apb_host (
  input wire logic pclk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  timeunit 1ns;
  timeprecision 1ns;
  logic hung;
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    hung = 1'b0;
  end
  // Call just after a rising edge; the request is held until pready is seen high or 16 access cycles pass
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
    output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    hung = (n >= 16);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Released lines flip so a stale value never passes for a live one
    paddr <= ~a;
    pwdata <= ~d;
    @(posedge pclk);
  endtask
endmodule

// >>> tb/mac_unit_chk.sv
// Bus and interrupt checker for the multiply-accumulate unit
module mac_unit_chk
  import mac_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic irq
);
  // ------------------------------
  // Bus and interrupt properties
  // ------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  logic mapped;
  assign mapped = (paddr <= MAC_OFS_IRQ_MSK) && (paddr[1:0] == 2'b00);
  sequence setup_s;
    psel && !penable;
  endsequence
  sequence mask_off_s;
    setup_s ##0 pwrite && paddr == MAC_OFS_IRQ_MSK && pwdata[1:0] == 2'b00;
  endsequence
  ready_in_access_a: assert property (setup_s |=> pready && psel && penable)
    else $error("no ready in access phase");
  ready_once_a: assert property (pready |=> !pready)
    else $error("ready held too long");
  ready_cause_a: assert property (pready |-> $past(psel && !penable))
    else $error("ready without setup");
  err_unmapped_a: assert property (setup_s ##0 !mapped |=> pslverr)
    else $error("unmapped access not refused");
  err_mapped_a: assert property (setup_s ##0 mapped |=> !pslverr)
    else $error("mapped access refused");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("error without ready");
  word_width_a: assert property (pready && !pwrite |-> prdata[31:16] == 16'h0000)
    else $error("read data wider than a word");
  irq_masked_a: assert property (mask_off_s |-> ##4 !irq)
    else $error("interrupt ignores mask");
endmodule

// >>> tb/testbench.sv
// Self-checking testbench for the multiply-accumulate unit
module testbench
  import mac_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [47:0] acc_m;
  logic [15:0] a, b;
  int miscompares, n_compared;
  mac_unit dut_u (.*);
  mac_apb_host host_u (.*);
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic xf(input logic w, input logic [11:0] ad, input logic [15:0] d);
    host_u.xfer(w, ad, {16'h0000, d}, r, e);
    if (host_u.hung) begin
      miscompares++;
      tally_and_finish();
    end
  endtask
  task automatic wait_idle();
    int n;
    n = 0;
    do begin
      xf(1'b0, MAC_OFS_CTL, 16'h0000);
      n++;
    end while (r[MAC_CTL_BUSY_BIT] !== 1'b0 && n < 8);
    if (n >= 8) begin
      miscompares++;
      tally_and_finish();
    end
  endtask
  task automatic chk_acc(input logic [47:0] exp);
    logic [47:0] v;
    xf(1'b0, MAC_OFS_ACC_UP, 16'h0000);
    v[47:32] = r[15:0];
    xf(1'b0, MAC_OFS_ACC_MID, 16'h0000);
    v[31:16] = r[15:0];
    xf(1'b0, MAC_OFS_ACC_LO, 16'h0000);
    v[15:0] = r[15:0];
    chk(v, exp);
  endtask
  task automatic set_acc(input logic [47:0] v);
    xf(1'b1, MAC_OFS_ACC_UP, v[47:32]);
    xf(1'b1, MAC_OFS_ACC_MID, v[31:16]);
    xf(1'b1, MAC_OFS_ACC_LO, v[15:0]);
    acc_m = v;
  endtask
  function automatic logic [47:0] model(input logic [47:0] acc, input logic [2:0] c,
    input logic [15:0] x, input logic [15:0] y);
    logic [47:0] p;
    p = c[0] ? {{32{x[15]}}, x} * {{32{y[15]}}, y} : {32'h0, x} * {32'h0, y};
    case (c[2:1])
      2'b01: return acc + p;
      2'b10: return acc - p;
      2'b11: return c[0] ? -p : p;
      default: return p;
    endcase
  endfunction
  initial begin
    presetn = 1'b0;
    miscompares = 0;
    n_compared = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    xf(1'b0, MAC_OFS_CTL, 16'h0000);
    chk(48'(r), 48'h0);
    chk_acc(48'h0);
    xf(1'b0, 12'h028, 16'h0000);
    chk({47'h0, e}, 48'h1);
    $display("test reset_and_map done");
    set_acc(48'h0123_4567_89AB);
    xf(1'b1, MAC_OFS_IRQ_MSK, 16'h0001);
    for (int i = 0; i < 8; i++) begin
      a = 16'hF00D + 16'(i);
      b = i[0] ? 16'h8ABC : 16'h1357;
      acc_m = model(acc_m, 3'(i), a, b);
      xf(1'b1, MAC_OFS_CTL, 16'(i));
      xf(1'b1, MAC_OFS_OPA, a);
      xf(1'b1, MAC_OFS_OPB, b);
      wait_idle();
      chk_acc(acc_m);
      if (i < 2) begin
        xf(1'b1, MAC_OFS_PROD_LO, 16'hFFFF);
        xf(1'b0, MAC_OFS_PROD_HI, 16'h0000);
        chk(48'(r), 48'(acc_m[31:16]));
        xf(1'b0, MAC_OFS_PROD_LO, 16'h0000);
        chk(48'(r), 48'(acc_m[15:0]));
      end
      chk(48'(irq), 48'h1);
      xf(1'b1, MAC_OFS_IRQ_STS, 16'h0001);
    end
    $display("test operations done");
    xf(1'b1, MAC_OFS_CTL, 16'h0103);
    set_acc(48'h7FFF_FFFF_FFFF);
    xf(1'b1, MAC_OFS_IRQ_MSK, 16'h0002);
    xf(1'b1, MAC_OFS_OPA, 16'h0001);
    xf(1'b1, MAC_OFS_OPB, 16'h0001);
    wait_idle();
    chk(48'(r[MAC_CTL_OVF_BIT]), 48'h1);
    chk_acc(48'h8000_0000_0000);
    chk(48'(irq), 48'h1);
    xf(1'b1, MAC_OFS_IRQ_STS, 16'h0003);
    xf(1'b1, MAC_OFS_CTL, 16'h0103);
    xf(1'b0, MAC_OFS_CTL, 16'h0000);
    chk(48'(r[MAC_CTL_OVF_BIT]), 48'h0);
    xf(1'b1, MAC_OFS_IRQ_MSK, 16'h0000);
    repeat (3) @(posedge pclk);
    chk(48'(irq), 48'h0);
    $display("test overflow done");
    tally_and_finish();
  end
endmodule

bind mac_unit mac_unit_chk chk_u (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .irq(irq));
